// ===== logic/slbp_pkg.sv
// Package with register map, reset values and timing counts of the loop and pointer bank
package slbp_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0]  DATA_PORT_OFS      = 8'hC5;
   localparam logic [7:0]  TXN_SELECT_OFS     = 8'hC6;
   localparam logic [7:0]  TXN_OFFSET_OFS     = 8'hC7;
   localparam logic [7:0]  BYTE_COUNTER_OFS   = 8'hC8;
   localparam logic [7:0]  REPEAT_COUNT_OFS   = 8'hC9;
   localparam logic [7:0]  REFRESH_OFS        = 8'hCA;
   localparam logic [7:0]  CLOCK_LOW_OFS      = 8'hCB;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int          TXN_SEL_W          = 6;
   localparam logic [7:0]  TXN_SELECT_RST     = 8'h00;
   localparam logic [7:0]  TXN_OFFSET_RST     = 8'h00;
   localparam logic [7:0]  BYTE_COUNTER_RST   = 8'h00;
   localparam logic [7:0]  REPEAT_COUNT_RST   = 8'h01;
   localparam logic [7:0]  REFRESH_RST        = 8'h00;
   localparam logic [7:0]  CLOCK_LOW_RST      = 8'h5E;
   localparam logic [7:0]  REPEAT_ENDLESS     = 8'h00;
   localparam logic [7:0]  REPEAT_ONCE        = 8'h01;
   localparam logic [7:0]  REFRESH_OFF        = 8'h00;
   localparam logic [7:0]  INVALID_DATA       = 8'hFF;
   localparam logic [7:0]  UNMAPPED_DATA      = 8'h00;

   // ----------------------------------------------------------------
   // Buffer geometry
   // ----------------------------------------------------------------
   localparam int          PTR_W              = 13;
   localparam logic [12:0] BUF_BYTES          = 13'h1100;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_KHZ            = 20000;
   localparam int          STEP_US            = 100;
   localparam int          STEP_CYC           = (STEP_US * CLK_KHZ) / 1000;
   localparam int          PRE_W              = 11;
   localparam logic [10:0] STEP_LAST          = 11'(STEP_CYC - 1);

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_WAIT} slbp_seq_e;
endpackage

// ===== logic/slbp_ctl_if.sv
// Interface joining the register bank to its pointer unit and refresh timer
`timescale 1ns/1ns
interface slbp_ctl_if;
   import slbp_pkg::*;
   logic              load;
   logic              step;
   logic [PTR_W-1:0]  base;
   logic [7:0]        offset;
   logic [PTR_W-1:0]  addr;
   logic              in_range;
   logic              restart;
   logic              run;
   logic [7:0]        interval;
   logic              tick;

   modport bank_ptr (output load, output step, output base, output offset,
                     input addr, input in_range);
   modport ptr      (input load, input step, input base, input offset,
                     output addr, output in_range);
   modport bank_tmr (output restart, output run, output interval, input tick);
   modport tmr      (input restart, input run, input interval, output tick);
endinterface

// ===== logic/slbp_buf_ptr.sv
// Auto-incrementing buffer pointer built from transaction base and byte offset
`timescale 1ns/1ns
module slbp_buf_ptr
   import slbp_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  srst,
   input  wire logic  ce,
   slbp_ctl_if.ptr    pif
);
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W-1:0] ptr_next;
   logic [PTR_W:0]   sum;

   // ----------------------------------------------------------------
   // Pointer arithmetic
   // ----------------------------------------------------------------
   // Load wins over step so a reposition is never lost to a data access
   always_comb
   begin
      sum      = {1'b0, pif.base} + {6'h00, pif.offset};
      ptr_next = ptr_reg;
      if (pif.load)
         ptr_next = sum[PTR_W-1:0];
      else if (pif.step)
         ptr_next = ptr_reg + 13'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         ptr_reg <= 13'h0000;
      else if (ce)
         ptr_reg <= ptr_next;
   end

   // Running past the end is flagged, not wrapped
   assign pif.addr     = ptr_reg;
   assign pif.in_range = (ptr_reg < BUF_BYTES);
endmodule

// ===== logic/slbp_refresh_timer.sv
// Refresh interval timer with 100 us steps spacing sequence starts
`timescale 1ns/1ns
module slbp_refresh_timer
   import slbp_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  srst,
   input  wire logic  ce,
   slbp_ctl_if.tmr    tif
);
   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] pre_next;
   logic [7:0]       step_reg;
   logic [7:0]       step_next;
   logic             tick_reg;
   logic             tick_next;

   // ----------------------------------------------------------------
   // Prescaler and step counter
   // ----------------------------------------------------------------
   // Free-running across passes so start-to-start spacing stays exact
   always_comb
   begin
      pre_next  = pre_reg;
      step_next = step_reg;
      tick_next = 1'b0;
      if (tif.restart || !tif.run)
      begin
         pre_next  = '0;
         step_next = 8'h00;
      end
      else if (pre_reg == STEP_LAST)
      begin
         pre_next = '0;
         if (step_reg + 8'h01 == tif.interval)
         begin
            step_next = 8'h00;
            tick_next = 1'b1;
         end
         else
            step_next = step_reg + 8'h01;
      end
      else
         pre_next = pre_reg + 11'h001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pre_reg  <= '0;
         step_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else if (ce)
      begin
         pre_reg  <= pre_next;
         step_reg <= step_next;
         tick_reg <= tick_next;
      end
   end

   assign tif.tick = tick_reg & tif.run;
endmodule

// ===== logic/slbp_regs.sv
// Channel register bank: buffer pointer, byte counter, sequence looping and SCL low period
//
// Summary of operation
// - Transaction select holds a six-bit slave entry index, 00h to 3Fh.
// - Byte offset holds an 8-bit index into the selected transaction's bytes.
// - Index and offset together form the pointer for data-port accesses.
// - Pointer beyond buffer sets buffer error, drops writes, reads give invalid data.
// - Host stays within transaction length; pointer otherwise runs into next region.
// - Byte counter is read-only, 8 bits, showing the live transfer count.
// - Counts acknowledged write bytes and all read bytes, masked transactions included.
// - Byte counter clears to zero at the start of every sequence.
// - Repeat count is read/write, resets to 01h, never counts down.
// - Repeat count 00h replays the sequence endlessly, STOP after each pass.
// - Repeat count 01h sends the sequence once, ending with STOP.
// - Repeat count above 01h runs exactly that many passes, STOP each time.
// - When looping without trigger mode, refresh sets start spacing in 100 us steps.
// - Refresh 00h, the reset value, disables the timer: passes run back-to-back.
// - Interval expiring mid-sequence sets frame error and requests an interrupt.
// - Repeat count of one ignores refresh and keeps the timer idle.
// - SCL low-period register is 8 bits, resets to 5Eh.
// - Writing the transaction index resets the byte offset to 00h.
// - Data port readable anytime, writable only while the channel is idle.
// - Pointer-reset bit returns the pointer to the index and offset position.
`timescale 1ns/1ns
module slbp_regs
   import slbp_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               ce,
   input  wire logic [7:0]         host_addr,
   input  wire logic [7:0]         host_wdata,
   input  wire logic               host_wr,
   input  wire logic               host_rd,
   output logic [7:0]              host_rdata,
   input  wire logic [PTR_W-1:0]   txn_base,
   output logic [TXN_SEL_W-1:0]    txn_index,
   output logic [PTR_W-1:0]        buf_addr,
   output logic [7:0]              buf_wdata,
   output logic                    buf_we,
   input  wire logic [7:0]         buf_rdata,
   input  wire logic               channel_idle,
   input  wire logic               pointer_reset_bit,
   input  wire logic               start_req,
   input  wire logic               trigger_enable,
   input  wire logic               trigger_pin,
   input  wire logic               pass_done,
   input  wire logic               byte_done,
   input  wire logic               byte_acked,
   input  wire logic               byte_is_read,
   output logic                    seq_go,
   output logic                    seq_active,
   output logic [7:0]              clock_low_period,
   output logic                    buffer_error_flag,
   input  wire logic               be_clear,
   output logic                    frame_error_flag,
   input  wire logic               fe_clear,
   output logic                    frame_error_irq
);
   slbp_ctl_if ctl ();

   logic [7:0]  sel_reg, sel_next, ofs_reg, ofs_next, cnt_reg, cnt_next;
   logic [7:0]  rep_reg, rep_next, ref_reg, ref_next, clock_low_period_reg, clock_low_period_next;
   logic        load_reg, load_next;
   logic [7:0]  wd_reg, wd_next, rd_reg, rd_next;
   logic        we_reg, we_next, wstep_reg, wstep_next;
   slbp_seq_e   st_reg, st_next;
   logic [7:0]  pass_reg, pass_next;
   logic        go_next;
   logic        be_reg, be_next, fe_reg, fe_next, irq_reg, irq_next;
   logic        trig_s1, trig_s2, trig_s3;
   logic        trig_edge, timer_on, data_wr, data_rd, counted;

   // Register address match, shared by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   slbp_buf_ptr u_ptr (.clk(clk), .srst(srst), .ce(ce), .pif(ctl.ptr));
   slbp_refresh_timer u_tmr (.clk(clk), .srst(srst), .ce(ce), .tif(ctl.tmr));

   assign data_wr = host_wr && hit(host_addr, DATA_PORT_OFS);
   assign data_rd = host_rd && hit(host_addr, DATA_PORT_OFS);
   // A read steps at once; an accepted write steps a cycle later, after its strobe used the address
   assign ctl.step   = (data_rd && !load_reg) || wstep_reg;
   assign ctl.load   = load_reg;
   assign ctl.base   = txn_base;
   assign ctl.offset = ofs_reg;

   // ----------------------------------------------------------------
   // Host-written registers
   // ----------------------------------------------------------------
   // Pointer reload is deferred one cycle so it sees the updated index and offset
   always_comb
   begin
      sel_next  = sel_reg;
      ofs_next  = ofs_reg;
      rep_next  = rep_reg;
      ref_next  = ref_reg;
      clock_low_period_next = clock_low_period_reg;
      load_next = pointer_reset_bit;
      if (host_wr)
      begin
         if (hit(host_addr, TXN_SELECT_OFS))
         begin
            sel_next  = {2'b00, host_wdata[TXN_SEL_W-1:0]};
            ofs_next  = 8'h00;
            load_next = 1'b1;
         end
         if (hit(host_addr, TXN_OFFSET_OFS))
         begin
            ofs_next  = host_wdata;
            load_next = 1'b1;
         end
         if (hit(host_addr, REPEAT_COUNT_OFS))
            rep_next = host_wdata;
         if (hit(host_addr, REFRESH_OFS))
            ref_next = host_wdata;
         if (hit(host_addr, CLOCK_LOW_OFS))
            clock_low_period_next = host_wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sel_reg  <= TXN_SELECT_RST;
         ofs_reg  <= TXN_OFFSET_RST;
         rep_reg  <= REPEAT_COUNT_RST;
         ref_reg  <= REFRESH_RST;
         clock_low_period_reg <= CLOCK_LOW_RST;
         load_reg <= 1'b0;
      end
      else if (ce)
      begin
         sel_reg  <= sel_next;
         ofs_reg  <= ofs_next;
         rep_reg  <= rep_next;
         ref_reg  <= ref_next;
         clock_low_period_reg <= clock_low_period_next;
         load_reg <= load_next;
      end
   end

   // ----------------------------------------------------------------
   // Trigger pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
      end
      else if (ce)
      begin
         trig_s1 <= trigger_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
      end
   end
   assign trig_edge = trig_s2 && !trig_s3;

   // ----------------------------------------------------------------
   // Sequence loop control
   // ----------------------------------------------------------------
   // Timer only matters when looping, not trigger-driven, and nonzero
   assign timer_on = (rep_reg != REPEAT_ONCE) && !trigger_enable
                     && (ref_reg != REFRESH_OFF);
   assign ctl.run      = timer_on && (st_reg != SEQ_IDLE);
   assign ctl.interval = ref_reg;
   assign ctl.restart  = go_next && (st_reg == SEQ_IDLE);

   always_comb
   begin
      st_next   = st_reg;
      pass_next = pass_reg;
      go_next   = 1'b0;
      case (st_reg)
         SEQ_IDLE:
         begin
            if (start_req)
            begin
               st_next   = SEQ_RUN;
               pass_next = rep_reg;
               go_next   = 1'b1;
            end
         end
         SEQ_RUN:
         begin
            // Every pass ends with STOP in the engine; here only the pass tally
            if (pass_done)
            begin
               if (rep_reg == REPEAT_ONCE)
                  st_next = SEQ_IDLE;
               else if (rep_reg == REPEAT_ENDLESS)
                  st_next = SEQ_WAIT;
               else if (pass_reg <= 8'h01)
                  st_next = SEQ_IDLE;
               else
               begin
                  pass_next = pass_reg - 8'h01;
                  st_next   = SEQ_WAIT;
               end
            end
         end
         SEQ_WAIT:
         begin
            if (trigger_enable ? trig_edge : (!timer_on || ctl.tick))
            begin
               st_next = SEQ_RUN;
               go_next = 1'b1;
            end
         end
         default:
            st_next = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_reg   <= SEQ_IDLE;
         pass_reg <= 8'h00;
      end
      else if (ce)
      begin
         st_reg   <= st_next;
         pass_reg <= pass_next;
      end
   end

   // ----------------------------------------------------------------
   // Byte counter, status flags and data-port path
   // ----------------------------------------------------------------
   // Flags are sticky; a set in the clearing cycle wins over the clear
   assign counted = byte_done && (byte_is_read || byte_acked);
   always_comb
   begin
      cnt_next = cnt_reg;
      if (go_next)
         cnt_next = 8'h00;
      else if (counted)
         cnt_next = cnt_reg + 8'h01;
      be_next  = (be_reg && !be_clear) || !ctl.in_range;
      irq_next = ctl.tick && (st_reg == SEQ_RUN);
      fe_next  = (fe_reg && !fe_clear) || irq_next;
      we_next  = data_wr && channel_idle && ctl.in_range;
      wstep_next = data_wr && channel_idle && !load_reg;
      wd_next  = data_wr ? host_wdata : wd_reg;
      rd_next  = rd_reg;
      if (host_rd)
      begin
         if (hit(host_addr, DATA_PORT_OFS))
            rd_next = ctl.in_range ? buf_rdata : INVALID_DATA;
         else if (hit(host_addr, TXN_SELECT_OFS))
            rd_next = sel_reg;
         else if (hit(host_addr, TXN_OFFSET_OFS))
            rd_next = ofs_reg;
         else if (hit(host_addr, BYTE_COUNTER_OFS))
            rd_next = cnt_reg;
         else if (hit(host_addr, REPEAT_COUNT_OFS))
            rd_next = rep_reg;
         else if (hit(host_addr, REFRESH_OFS))
            rd_next = ref_reg;
         else if (hit(host_addr, CLOCK_LOW_OFS))
            rd_next = clock_low_period_reg;
         else
            rd_next = UNMAPPED_DATA;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg <= BYTE_COUNTER_RST;
         be_reg  <= 1'b0;
         fe_reg  <= 1'b0;
         irq_reg <= 1'b0;
         we_reg  <= 1'b0;
         wstep_reg <= 1'b0;
         wd_reg  <= 8'h00;
         rd_reg  <= 8'h00;
      end
      else if (ce)
      begin
         cnt_reg <= cnt_next;
         be_reg  <= be_next;
         fe_reg  <= fe_next;
         irq_reg <= irq_next;
         we_reg  <= we_next;
         wstep_reg <= wstep_next;
         wd_reg  <= wd_next;
         rd_reg  <= rd_next;
      end
   end

   // Write strobe is registered, so the address it pairs with is held one cycle
   assign host_rdata        = rd_reg;
   assign txn_index         = sel_reg[TXN_SEL_W-1:0];
   assign buf_addr          = ctl.addr;
   assign buf_wdata         = wd_reg;
   assign buf_we            = we_reg;
   assign seq_go            = go_next;
   assign seq_active        = (st_reg != SEQ_IDLE);
   assign clock_low_period  = clock_low_period_reg;
   assign buffer_error_flag = be_reg;
   assign frame_error_flag  = fe_reg;
   assign frame_error_irq   = irq_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || !ce);

   sel_reserved_a: assert property (sel_reg[7:6] == 2'b00)
      else $error("reserved select bits not zero");
   ofs_cleared_a: assert property (host_wr && hit(host_addr, TXN_SELECT_OFS)
      && !hit(host_addr, TXN_OFFSET_OFS) |=> ofs_reg == 8'h00)
      else $error("offset not cleared by index write");
   ptr_reload_a: assert property (load_reg && ce |=> buf_addr ==
      PTR_W'($past(txn_base) + {5'h00, $past(ofs_reg)}))
      else $error("pointer not reloaded from index and offset");
   cnt_clear_a: assert property (go_next |=> cnt_reg == 8'h00)
      else $error("byte counter not cleared at start");
   cnt_count_a: assert property (counted && !go_next
      |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("counted byte missed");
   cnt_nack_a: assert property (!counted && !go_next |=> $stable(cnt_reg))
      else $error("byte counter moved without a counted byte");
   rep_held_a: assert property (!host_wr |=> $stable(rep_reg))
      else $error("repeat count changed without a write");
   once_end_a: assert property (st_reg == SEQ_RUN && pass_done
      && rep_reg == REPEAT_ONCE |=> st_reg == SEQ_IDLE)
      else $error("single pass did not finish");
   endless_loop_a: assert property (st_reg == SEQ_RUN && pass_done
      && rep_reg == REPEAT_ENDLESS |=> st_reg == SEQ_WAIT)
      else $error("endless loop stopped");
   timer_idle_a: assert property (rep_reg == REPEAT_ONCE |-> !ctl.run)
      else $error("timer running with single pass");
   frame_err_a: assert property (ctl.tick && st_reg == SEQ_RUN
      |=> frame_error_flag && frame_error_irq ##1 !frame_error_irq)
      else $error("frame error not raised");
   write_guard_a: assert property (buf_we |-> $past(channel_idle)
      && $past(ctl.in_range))
      else $error("buffer written while busy or out of range");

   multi_pass_c: cover property (st_reg == SEQ_WAIT && rep_reg > REPEAT_ONCE
      ##[1:1000] seq_go);
   frame_err_c: cover property (irq_next);
   out_range_c: cover property (data_wr && !ctl.in_range);
endmodule

// ===== tb/slbp_buf_model.sv
// Behavioural channel buffer answering the bank's pointer
`timescale 1ns/1ns
module slbp_buf_model
   import slbp_pkg::*;
(
   input  wire logic             clk,
   input  wire logic [PTR_W-1:0] addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             we,
   output logic [7:0]            rdata
);
   logic [7:0] mem [0:8191];
   // Store only on the bank's write pulse; unwritten bytes stay unknown on purpose
   always @(posedge clk)
   begin
      if (we)
         mem[addr] <= wdata;
   end
   assign rdata = mem[addr];
endmodule

// ===== tb/slbp_regs_bench.sv
// Self-checking bench for the loop and pointer register bank
`timescale 1ns/1ns
module slbp_regs_bench;
   import slbp_pkg::*;
   logic                 clk, srst, host_wr, host_rd, channel_idle, byte_acked, byte_is_read;
   logic [7:0]           host_addr, host_wdata, host_rdata, buf_wdata, buf_rdata, low_p, v;
   logic [4:0]           ev;
   logic [TXN_SEL_W-1:0] txn_index;
   logic [PTR_W-1:0]     buf_addr;
   logic                 buf_we, seq_go, seq_active, be_f, fe_f, fe_irq, te, tp;
   int                   num_errors, num_checks, cyc, n, gos, irqs;
   int                   q[$];
   logic [7:0]           ra [7] = '{8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hD0};
   logic [7:0]           rv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h5E, 8'h00};

   // Region base of a transaction is its index times 128 bytes in this bench
   slbp_regs dut (.clk(clk), .srst(srst), .ce(1'b1), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
      .txn_base({txn_index, 7'h00}), .txn_index(txn_index), .buf_addr(buf_addr),
      .buf_wdata(buf_wdata), .buf_we(buf_we), .buf_rdata(buf_rdata),
      .channel_idle(channel_idle), .pointer_reset_bit(ev[3]), .start_req(ev[0]),
      .trigger_enable(te), .trigger_pin(tp), .pass_done(ev[1]), .byte_done(ev[2]),
      .byte_acked(byte_acked), .byte_is_read(byte_is_read), .seq_go(seq_go),
      .seq_active(seq_active), .clock_low_period(low_p), .buffer_error_flag(be_f),
      .be_clear(ev[4]), .frame_error_flag(fe_f), .fe_clear(1'b0), .frame_error_irq(fe_irq));
   slbp_buf_model mem (.clk(clk), .addr(buf_addr), .wdata(buf_wdata), .we(buf_we),
      .rdata(buf_rdata));

   task chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   // One access per call, with an idle cycle before the next one
   task acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      host_wr = w;
      host_rd = !w;
      @(negedge clk);
      host_wr = 0;
      host_rd = 0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      acc(a, 8'h00, 1'b0);
      chk("read data", {5'h00, host_rdata}, {5'h00, e});
   endtask
   task pl(input int k);
      @(negedge clk);
      ev[k] = 1;
      @(negedge clk);
      ev[k] = 0;
   endtask
   task finish_test;
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Cut a hang short well past the longest scenario; tally pass starts and frame interrupts
   always @(posedge clk)
   begin
      cyc++;
      gos += seq_go;
      irqs += fe_irq;
      if (cyc == 20000)
      begin
         num_errors++;
         finish_test;
      end
   end

   initial
   begin
      {srst, host_wr, host_rd, host_addr, host_wdata, ev} = {1'b1, 23'h0};
      {channel_idle, byte_acked, byte_is_read, te, tp} = 5'b10000;
      v = 8'($urandom(14));
      repeat (4) @(negedge clk);
      srst = 0;
      foreach (ra[i]) rchk(ra[i], rv[i]);
      acc(8'hC8, 8'hFF, 1'b1);
      rchk(8'hC8, 8'h00);
      v = 8'($urandom);
      acc(8'hCB, v, 1'b1);
      chk("low period", {5'h00, low_p}, {5'h00, v});
      acc(8'hC6, 8'hFF, 1'b1);
      rchk(8'hC6, 8'h3F);
      acc(8'hC7, 8'h09, 1'b1);
      acc(8'hC6, 8'h05, 1'b1);
      rchk(8'hC7, 8'h00);
      // Start one byte before the region end so the writes run into region 6
      acc(8'hC7, 8'h7F, 1'b1);
      repeat (2) @(negedge clk);
      chk("pointer", buf_addr, 13'(5 * 128 + 127));
      // A busy-time write ahead of each accepted one must neither land nor step
      repeat (3)
      begin
         channel_idle = 0;
         acc(8'hC5, ~v, 1'b1);
         channel_idle = 1;
         v = 8'($urandom);
         q.push_back(v);
         acc(8'hC5, v, 1'b1);
      end
      pl(3);
      foreach (q[i]) rchk(8'hC5, 8'(q[i]));
      acc(8'hC6, 8'h06, 1'b1);
      rchk(8'hC5, 8'(q[1]));
      pl(4);
      chk("buffer error", be_f, 0);
      acc(8'hC6, 8'h3F, 1'b1);
      repeat (2) @(negedge clk);
      chk("buffer error", be_f, 1);
      rchk(8'hC5, 8'hFF);
      // Two passes; acked writes and read bytes count, a refused write does not
      acc(8'hC9, 8'h02, 1'b1);
      pl(0);
      n = 0;
      for (int i = 0; i < 4; i++)
      begin
         {byte_acked, byte_is_read} = 2'(i + 1);
         n += (i != 3);
         pl(2);
      end
      rchk(8'hC8, 8'(n));
      pl(1);
      repeat (3) @(negedge clk);
      rchk(8'hC8, 8'h00);
      chk("active", seq_active, 1);
      pl(1);
      repeat (2) @(negedge clk);
      chk("active", seq_active, 0);
      chk("starts", gos, 2);
      // Trigger mode holds the second pass for the pin; the interval timer stays out
      te = 1;
      acc(8'hCA, 8'h01, 1'b1);
      pl(0);
      pl(1);
      repeat (STEP_CYC + 10) @(negedge clk);
      chk("starts", gos, 3);
      chk("frame error", fe_f, 0);
      tp = 1;
      repeat (5) @(negedge clk);
      chk("starts", gos, 4);
      pl(1);
      te = 0;
      // Endless loop with a 100 us interval and a pass that never ends
      acc(8'hCA, 8'h01, 1'b1);
      acc(8'hC9, 8'h00, 1'b1);
      pl(0);
      repeat (STEP_CYC + 100) @(negedge clk);
      chk("frame error", fe_f, 1);
      chk("frame irq", irqs, 1);
      finish_test;
   end
endmodule
